//--- trap_control_vector_gen.sv
// trap selection, floating-point trap gating and trap vector generation
//
// Function
// RULE1: take only the highest-priority outstanding trap
// RULE2: among interrupts pick the greatest level
// RULE3: interrupt traps only when level exceeds limit
// RULE4: fp traps gated by both enables and mask
// RULE5: enabled ieee exception raises ieee trap
// RULE6: disabled ieee exception accrues, no trap
// RULE7: trapping ieee exception leaves results unchanged
// RULE8: non-trapping ieee exception commits new results
// RULE9: privileged traps use little-endian select bit
// RULE10: hyperprivileged traps always big-endian
// RULE11: nesting level picks execute, red, error state
// RULE12: destination from type, level, detecting mode
// RULE13: separate bases for privileged and hyper traps
// RULE14: software loads upper 49 privileged base bits
// RULE15: software loads upper 50 hyper base bits
// RULE16: privileged vector high bits from base
// RULE17: privileged bit 14 marks nonzero level
// RULE18: vector bits 13:5 carry trap type
// RULE19: vector low five bits always zero
// RULE20: hyper vector high bits from base
// RULE21: privileged table halves by level zero
// RULE22: write trap type at current level
// RULE23: hyper-detected privileged interrupt stays pending
// RULE24: select format, present address when taken
//
// Decided for this implementation: the strobed register port and the address map.
`default_nettype none
`include "trap_vec_cfg.svh"

module trap_control_vector_gen (
    input  wire logic                              i_core_clk,
    input  wire logic                              i_rst,
    input  wire logic [5:0]                        i_reg_addr,
    input  wire logic [63:0]                       i_reg_wdata,
    input  wire logic                              i_reg_wr,
    input  wire logic                              i_reg_rd,
    output logic      [63:0]                       o_reg_rdata,
    input  wire logic                              i_boundary,
    input  wire trap_vec_pkg::exc_req_s [3:0]      i_exc,
    input  wire logic [15:0]                       i_irq_pend,
    input  wire trap_vec_pkg::cpu_state_s          i_cpu,
    input  wire trap_vec_pkg::fp_result_s          i_fp,
    input  wire logic                              i_trap_ret,
    output logic                                   o_fp_commit,
    output logic      [2:0]                        o_tl,
    output trap_vec_pkg::trap_out_s                o_trap
);

    // -------------------------------------------------------------------------
    // vector formats
    // -------------------------------------------------------------------------
    function automatic logic [63:0] priv_vec(input logic [63:0] base,
                                             input logic [2:0]  tl,
                                             input logic [8:0]  ttc);
        logic [63:0] v;
        v = 64'h0000000000000000;
        v[63:`PTB_LO] = base[63:`PTB_LO];                 // [RULE16] [RULE13]
        v[`VEC_TL_BIT] = (tl != 3'd0);                    // [RULE17] [RULE21]
        v[`VEC_TT_HI:`VEC_TT_LO] = ttc;                   // [RULE18]
        v[4:0] = 5'h00;                                   // [RULE19]
        return v;
    endfunction

    function automatic logic [63:0] hyper_vec(input logic [63:0] base,
                                              input logic [8:0]  ttc);
        logic [63:0] v;
        v = 64'h0000000000000000;
        v[63:`HTB_LO] = base[63:`HTB_LO];                 // [RULE20] [RULE13]
        v[`VEC_TT_HI:`VEC_TT_LO] = ttc;                   // [RULE18]
        v[4:0] = 5'h00;                                   // [RULE19]
        return v;
    endfunction

    function automatic logic [63:0] fsr_word(input logic [4:0] tem,
                                             input logic [4:0] aexc,
                                             input logic [7:0] fcc);
        logic [63:0] w;
        w = 64'h0000000000000000;
        w[`FSR_TEM_LO +: 5] = tem;
        w[`FSR_AEXC_LO +: 5] = aexc;
        w[`FSR_FCC_LO +: 8] = fcc;
        return w;
    endfunction

    // -------------------------------------------------------------------------
    // state
    // -------------------------------------------------------------------------
    trap_vec_pkg::unit_state_s st_r;
    trap_vec_pkg::unit_state_s st_nxt;

    // -------------------------------------------------------------------------
    // interrupt pick
    // -------------------------------------------------------------------------
    logic       irq_any;
    logic [3:0] irq_lvl;
    logic       irq_ok;

    always_comb begin
        irq_any = 1'b0;
        irq_lvl = 4'h0;
        for (int i = 1; i < `IRQ_LEVELS; i++) begin
            if (i_irq_pend[i]) begin
                irq_any = 1'b1;                           // [RULE2]
                irq_lvl = 4'(i);
            end
        end
        irq_ok = irq_any
            && !i_cpu.hyper_priv                          // [RULE23]
            && i_cpu.interrupt_enable
            && (irq_lvl > st_r.processor_irq_level);                      // [RULE3]
    end

    // -------------------------------------------------------------------------
    // floating-point gating
    // -------------------------------------------------------------------------
    logic       fp_on;
    logic [4:0] fp_hit;
    logic       fp_trap;

    always_comb begin
        fp_on = i_cpu.float_unit_enable && i_cpu.fp_enable;   // [RULE4]
        fp_hit = i_fp.cexc & st_r.tem;                        // [RULE5]
        fp_trap = i_fp.valid && fp_on && (fp_hit != 5'h00);   // [RULE4] [RULE5]
        o_fp_commit = i_fp.valid && fp_on && !fp_trap;        // [RULE7] [RULE8]
    end

    // -------------------------------------------------------------------------
    // trap selection
    // -------------------------------------------------------------------------
    logic       sel_vld;
    logic [8:0] sel_tt;
    logic [7:0] sel_prio;
    logic       sel_hyp;

    always_comb begin
        sel_vld = 1'b0;
        sel_tt = 9'h000;
        sel_prio = 8'hFF;
        sel_hyp = 1'b0;
        for (int i = 0; i < `NUM_EXC; i++) begin
            if (i_exc[i].valid && (!sel_vld || i_exc[i].prio < sel_prio)) begin
                sel_vld = 1'b1;                           // [RULE1]
                sel_tt = i_exc[i].trap_type_code;
                sel_prio = i_exc[i].prio;
                sel_hyp = i_exc[i].to_hyper;
            end
        end
        if (st_r.fp_pend && (!sel_vld || `FP_PRIO < sel_prio)) begin
            sel_vld = 1'b1;                               // [RULE1]
            sel_tt = `FP_IEEE_TT;
            sel_prio = `FP_PRIO;
            sel_hyp = 1'b0;
        end
        if (irq_ok && (!sel_vld || `IRQ_PRIO < sel_prio)) begin
            sel_vld = 1'b1;                               // [RULE3] [RULE1]
            sel_tt = `IRQ_TT_BASE + {5'h00, irq_lvl};
            sel_prio = `IRQ_PRIO;
            sel_hyp = 1'b0;
        end
    end

    // -------------------------------------------------------------------------
    // destination and state after the trap
    // -------------------------------------------------------------------------
    logic                      take;
    logic                      dst_hyp;
    logic [2:0]                tl_new;
    trap_vec_pkg::proc_state_e dst_state;

    always_comb begin
        take = i_boundary && sel_vld;                     // [RULE1]
        dst_hyp = sel_hyp
            || i_cpu.hyper_priv
            || (st_r.tl >= `MAX_PTL);                     // [RULE12] [RULE11]
        if (st_r.tl == `MAX_TL) begin
            dst_state = trap_vec_pkg::ST_ERROR;           // [RULE11]
            tl_new = `MAX_TL;
        end else if (st_r.tl == `MAX_TL - 3'd1) begin
            dst_state = trap_vec_pkg::ST_RED;             // [RULE11]
            tl_new = `MAX_TL;
        end else begin
            dst_state = trap_vec_pkg::ST_EXECUTE;         // [RULE11]
            tl_new = st_r.tl + 3'd1;
        end
    end

    // -------------------------------------------------------------------------
    // next state
    // -------------------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.rdata = 64'h0000000000000000;
        st_nxt.trap.valid = 1'b0;

        // register writes; software owns the upper base bits
        if (i_reg_wr) begin
            unique case (i_reg_addr)
                `ADDR_PTB: st_nxt.ptb = i_reg_wdata;      // [RULE14]
                `ADDR_HTB: st_nxt.htb = i_reg_wdata;      // [RULE15]
                `ADDR_FSR: begin
                    st_nxt.tem = i_reg_wdata[`FSR_TEM_LO +: 5];
                    st_nxt.aexc = i_reg_wdata[`FSR_AEXC_LO +: 5];
                    st_nxt.fcc = i_reg_wdata[`FSR_FCC_LO +: 8];
                end
                `ADDR_PIL: st_nxt.processor_irq_level = i_reg_wdata[3:0];
                `ADDR_TL: begin
                    if (i_reg_wdata[2:0] <= `MAX_TL) begin
                        st_nxt.tl = i_reg_wdata[2:0];
                    end
                end
                `ADDR_TT: st_nxt.tt[st_r.tl] = i_reg_wdata[8:0];
                default: ;
            endcase
        end

        // register reads, answer in the next cycle
        if (i_reg_rd) begin
            unique case (i_reg_addr)
                `ADDR_PTB: st_nxt.rdata = st_r.ptb;
                `ADDR_HTB: st_nxt.rdata = st_r.htb;
                `ADDR_FSR: st_nxt.rdata = fsr_word(st_r.tem, st_r.aexc, st_r.fcc);
                `ADDR_PIL: st_nxt.rdata = {60'h0, st_r.processor_irq_level};
                `ADDR_TL:  st_nxt.rdata = {61'h0, st_r.tl};
                `ADDR_TT:  st_nxt.rdata = {55'h0, st_r.tt[st_r.tl]};
                `ADDR_VEC: st_nxt.rdata = st_r.trap.vector;
                default:   st_nxt.rdata = 64'h0000000000000000;
            endcase
        end

        // fp results; hardware fcc wins over a same-cycle write, cexc ORs into the written aexc
        if (o_fp_commit) begin
            st_nxt.aexc = st_nxt.aexc | i_fp.cexc;        // [RULE6] [RULE8]
            st_nxt.fcc = i_fp.fcc;                        // [RULE8]
        end

        // trap return lowers the nesting level
        if (i_trap_ret && st_r.tl != 3'd0) begin
            st_nxt.tl = st_r.tl - 3'd1;
        end

        // take the selected trap
        if (take) begin
            st_nxt.tl = tl_new;
            st_nxt.tt[tl_new] = sel_tt;                   // [RULE22]
            st_nxt.trap.valid = 1'b1;
            st_nxt.trap.trap_type_code = sel_tt;
            st_nxt.trap.to_hyper = dst_hyp;
            st_nxt.trap.next_state = dst_state;
            st_nxt.trap.little_endian = !dst_hyp
                && i_cpu.trap_little_endian;              // [RULE9] [RULE10]
            if (dst_hyp) begin
                st_nxt.trap.vector = hyper_vec(st_r.htb, sel_tt);   // [RULE24]
            end else begin
                st_nxt.trap.vector = priv_vec(st_r.ptb, st_r.tl,
                                              sel_tt);              // [RULE24]
            end
        end

        // fp trap stays pending until taken; a new one wins over the take
        if (take && sel_tt == `FP_IEEE_TT && st_r.fp_pend) begin
            st_nxt.fp_pend = 1'b0;
        end
        if (fp_trap) begin
            st_nxt.fp_pend = 1'b1;                        // [RULE5] [RULE7]
        end
    end

    // -------------------------------------------------------------------------
    // registers
    // -------------------------------------------------------------------------
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            st_r.ptb <= `RST_BASE;
            st_r.htb <= `RST_BASE;
            st_r.tem <= 5'h00;
            st_r.aexc <= 5'h00;
            st_r.fcc <= 8'h00;
            st_r.processor_irq_level <= `RST_PIL;
            st_r.tl <= `RST_TL;
            st_r.tt <= '0;
            st_r.fp_pend <= 1'b0;
            st_r.rdata <= 64'h0000000000000000;
            st_r.trap.valid <= 1'b0;
            st_r.trap.vector <= 64'h0000000000000000;
            st_r.trap.trap_type_code <= 9'h000;
            st_r.trap.to_hyper <= 1'b0;
            st_r.trap.little_endian <= 1'b0;
            st_r.trap.next_state <= trap_vec_pkg::ST_EXECUTE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // -------------------------------------------------------------------------
    // outputs
    // -------------------------------------------------------------------------
    assign o_reg_rdata = st_r.rdata;
    assign o_tl = st_r.tl;
    assign o_trap = st_r.trap;

endmodule

`default_nettype wire

//--- trap_vec_cfg.svh
// offsets, field positions, reset values and limits of the trap vector unit
`ifndef TRAP_VEC_CFG_SVH
`define TRAP_VEC_CFG_SVH

// -----------------------------------------------------------------------------
// register offsets
// -----------------------------------------------------------------------------
`define ADDR_PTB     6'h00
`define ADDR_HTB     6'h08
`define ADDR_FSR     6'h10
`define ADDR_PIL     6'h18
`define ADDR_TL      6'h20
`define ADDR_TT      6'h28
`define ADDR_VEC     6'h30

// -----------------------------------------------------------------------------
// field positions
// -----------------------------------------------------------------------------
`define PTB_LO       15
`define HTB_LO       14
`define VEC_TL_BIT   14
`define VEC_TT_LO    5
`define VEC_TT_HI    13
`define FSR_TEM_LO   0
`define FSR_AEXC_LO  8
`define FSR_FCC_LO   16

// -----------------------------------------------------------------------------
// sizes, limits, codes and reset values
// -----------------------------------------------------------------------------
`define NUM_EXC      4
`define MAX_TL       3'd6
`define MAX_PTL      3'd2
`define IRQ_LEVELS   16
`define IRQ_TT_BASE  9'h040
`define FP_IEEE_TT   9'h021
`define IRQ_PRIO     8'h20
`define FP_PRIO      8'h10
`define RST_BASE     64'h0000000000000000
`define RST_TL       3'd0
`define RST_PIL      4'h0

`endif

//--- trap_vec_pkg.sv
// types shared by the trap vector unit and its neighbours
`default_nettype none
`include "trap_vec_cfg.svh"

package trap_vec_pkg;

    // -------------------------------------------------------------------------
    // enumerations
    // -------------------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_EXECUTE,
        ST_RED,
        ST_ERROR
    } proc_state_e;

    // -------------------------------------------------------------------------
    // carriers
    // -------------------------------------------------------------------------
    typedef struct packed {
        logic       valid;
        logic [8:0] trap_type_code;
        logic [7:0] prio;
        logic       to_hyper;
    } exc_req_s;

    typedef struct packed {
        logic interrupt_enable;
        logic fp_enable;
        logic trap_little_endian;
        logic hyper_priv;
        logic float_unit_enable;
    } cpu_state_s;

    typedef struct packed {
        logic       valid;
        logic [4:0] cexc;
        logic [7:0] fcc;
    } fp_result_s;

    typedef struct packed {
        logic        valid;
        logic [63:0] vector;
        logic [8:0]  trap_type_code;
        logic        to_hyper;
        logic        little_endian;
        proc_state_e next_state;
    } trap_out_s;

    typedef struct packed {
        logic [63:0]        ptb;
        logic [63:0]        htb;
        logic [4:0]         tem;
        logic [4:0]         aexc;
        logic [7:0]         fcc;
        logic [3:0]         processor_irq_level;
        logic [2:0]         tl;
        logic [6:0][8:0]    tt;
        logic               fp_pend;
        logic [63:0]        rdata;
        trap_out_s          trap;
    } unit_state_s;

endpackage

`default_nettype wire

//--- trap_vec_props.sv
// concurrent checks on the trap vector unit ports
`default_nettype none
module trap_vec_props (
    input wire logic                     i_core_clk,
    input wire logic                     i_rst,
    input wire logic                     i_boundary,
    input wire logic [15:0]              i_irq_pend,
    input wire trap_vec_pkg::cpu_state_s i_cpu,
    input wire trap_vec_pkg::fp_result_s i_fp,
    input wire logic                     o_fp_commit,
    input wire logic [2:0]               o_tl,
    input wire trap_vec_pkg::trap_out_s  o_trap
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    property p_low_zero; o_trap.valid |-> o_trap.vector[4:0] == 5'h00; endproperty
    a_low_zero: assert property (p_low_zero) else $error("vector low bits set");
    property p_tt_field;
        o_trap.valid |-> o_trap.vector[13:5] == o_trap.trap_type_code;
    endproperty
    a_tt_field: assert property (p_tt_field) else $error("vector type field wrong");
    property p_hyper_be; o_trap.valid && o_trap.to_hyper |-> !o_trap.little_endian; endproperty
    a_hyper_be: assert property (p_hyper_be) else $error("hyper trap not big endian");
    property p_priv_le;
        o_trap.valid && !o_trap.to_hyper
            |-> o_trap.little_endian == $past(i_cpu.trap_little_endian);
    endproperty
    a_priv_le: assert property (p_priv_le) else $error("byte order select wrong");
    property p_bit14;
        o_trap.valid && !o_trap.to_hyper |-> o_trap.vector[14] == ($past(o_tl) != 3'h0);
    endproperty
    a_bit14: assert property (p_bit14) else $error("table half bit wrong");
    property p_boundary; !i_boundary |=> !o_trap.valid; endproperty
    a_boundary: assert property (p_boundary) else $error("trap off boundary");
    property p_irq_gate;
        o_trap.valid && o_trap.trap_type_code[8:4] == 5'h04
            |-> $past(i_cpu.interrupt_enable) && !$past(i_cpu.hyper_priv);
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("masked irq taken");
    property p_irq_pick;
        o_trap.valid && o_trap.trap_type_code[8:4] == 5'h04
            |-> ($past(i_irq_pend) >> o_trap.trap_type_code[3:0]) == 16'h0001;
    endproperty
    a_irq_pick: assert property (p_irq_pick) else $error("irq level not highest");
    property p_commit; o_fp_commit |-> i_fp.valid && i_cpu.fp_enable && i_cpu.float_unit_enable;
    endproperty
    a_commit: assert property (p_commit) else $error("fp commit ungated");
    property p_tl_step;
        o_trap.valid |-> o_tl == (($past(o_tl) == 3'h6) ? 3'h6 : $past(o_tl) + 3'h1);
    endproperty
    a_tl_step: assert property (p_tl_step) else $error("nesting step wrong");
endmodule
bind trap_control_vector_gen trap_vec_props u_props (.i_core_clk(i_core_clk), .i_rst(i_rst),
    .i_boundary(i_boundary), .i_irq_pend(i_irq_pend), .i_cpu(i_cpu), .i_fp(i_fp),
    .o_fp_commit(o_fp_commit), .o_tl(o_tl), .o_trap(o_trap));
`default_nettype wire

//--- pipe_model.sv
// pipeline model: holds exceptions until taken, drives boundary and return
`default_nettype none
module pipe_model (
    input  wire logic                         i_core_clk,
    input  wire logic                         i_rst,
    input  wire logic                         i_post,
    input  wire trap_vec_pkg::exc_req_s [3:0] i_req,
    input  wire logic                         i_step,
    input  wire logic                         i_ret,
    input  wire trap_vec_pkg::trap_out_s      i_trap,
    output logic                              o_boundary,
    output logic                              o_trap_ret,
    output trap_vec_pkg::exc_req_s [3:0]      o_exc
);
    timeunit 1ns;
    timeprecision 1ps;
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_boundary <= 1'b0;
            o_trap_ret <= 1'b0;
            o_exc      <= '0;
        end else begin
            o_boundary <= i_step;
            o_trap_ret <= i_ret;
            if (i_post) o_exc <= i_req;
            // a taken exception is retired and its payload scrambled
            for (int k = 0; k < 4; k++) begin
                if (i_trap.valid && o_exc[k].trap_type_code == i_trap.trap_type_code)
                    o_exc[k] <= {1'b0, ~o_exc[k][17:0]};
            end
        end
    end
endmodule
`default_nettype wire

//--- test_trap_control_vector_gen.sv
// bench for the trap vector unit
`default_nettype none
`include "trap_vec_cfg.svh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin failures++; $display("BAD %0t mismatch", $time); end end
module test_trap_control_vector_gen;
    timeunit 1ns;
    timeprecision 1ps;
    logic                         clk = 1'b0, rst = 1'b1, wr, rd, post, stp, ret, bnd, tret, cm, rd_q;
    logic [5:0]                   addr;
    logic [63:0]                  wdata, rdata, ptb, htb, v;
    logic [2:0]                   tl;
    logic [15:0]                  irq;
    logic [8:0]                   tt;
    trap_vec_pkg::exc_req_s [3:0] req, exc;
    trap_vec_pkg::exc_req_s       nz;
    trap_vec_pkg::cpu_state_s     cpu;
    trap_vec_pkg::fp_result_s     fp;
    trap_vec_pkg::trap_out_s      trap;
    trap_vec_pkg::trap_out_s      exp_tr[$];
    logic [63:0]                  exp_rd[$];
    logic                         exp_cm[$];
    int                           failures = 0, n_checks = 0;
    localparam logic [23:0]       ITAB [5] = '{24'h010028, 24'h910288, 24'h000200, 24'h030200,
                                               24'hF18000};
    always #4 clk = ~clk;
    trap_control_vector_gen dut_u (.i_core_clk(clk), .i_rst(rst), .i_reg_addr(addr),
        .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata),
        .i_boundary(bnd), .i_exc(exc), .i_irq_pend(irq), .i_cpu(cpu), .i_fp(fp),
        .i_trap_ret(tret), .o_fp_commit(cm), .o_tl(tl), .o_trap(trap));
    pipe_model pipe_u (.i_core_clk(clk), .i_rst(rst), .i_post(post), .i_req(req),
        .i_step(stp), .i_ret(ret), .i_trap(trap), .o_boundary(bnd), .o_trap_ret(tret),
        .o_exc(exc));
    // ------------------------------------------------------------------------
    // result watcher
    // ------------------------------------------------------------------------
    always @(negedge clk) begin
        if (rd_q) `CHK(rdata, exp_rd.size() ? exp_rd.pop_front() : ~rdata)
        if (trap.valid === 1'b1) `CHK(trap, exp_tr.size() ? exp_tr.pop_front() : '0)
        if (fp.valid) `CHK(cm, exp_cm.size() ? exp_cm.pop_front() : ~cm)
        rd_q = rd;
    end
    function automatic trap_vec_pkg::trap_out_s et(input logic h, input logic [2:0] t,
                                                   input logic [8:0] c, input logic le);
        trap_vec_pkg::proc_state_e s;
        s = (t == 3'h6) ? trap_vec_pkg::ST_ERROR : (t == 3'h5) ? trap_vec_pkg::ST_RED
                                                               : trap_vec_pkg::ST_EXECUTE;
        et = '{1'b1, h ? {htb[63:14], c, 5'h00} : {ptb[63:15], t != 3'h0, c, 5'h00}, c, h,
               h ? 1'b0 : le, s};
    endfunction
    function automatic trap_vec_pkg::exc_req_s mk(input logic [8:0] t, input logic [7:0] p,
                                                  input logic h);
        mk = '{1'b1, t, p, h};
    endfunction
    task automatic wreg(input logic [5:0] a, input logic [63:0] d);
        @(posedge clk) {addr, wdata, wr} <= {a, d, 1'b1};
        @(posedge clk) wr <= 1'b0;
    endtask
    task automatic rreg(input logic [5:0] a, input logic [63:0] e);
        exp_rd.push_back(e);
        @(posedge clk) {addr, rd} <= {a, 1'b1};
        @(posedge clk) rd <= 1'b0;
    endtask
    task automatic give(input trap_vec_pkg::exc_req_s [3:0] r);
        @(posedge clk) {post, req} <= {1'b1, r};
        @(posedge clk) post <= 1'b0;
    endtask
    task automatic step();
        @(posedge clk) stp <= 1'b1;
        @(posedge clk) stp <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    task automatic fpop(input logic [4:0] c, input logic [7:0] f, input logic e);
        exp_cm.push_back(e);
        @(posedge clk) fp <= '{1'b1, c, f};
        @(posedge clk) fp.valid <= 1'b0;
    endtask
    task automatic end_sim();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        end_sim();
    end
    initial begin
        {wr, rd, post, stp, ret, rd_q, addr, wdata, irq, req, cpu, fp} = '0;
        v = $urandom(32'h666B0EA9);
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rreg(`ADDR_PTB, 64'h0);
        rreg(`ADDR_VEC, 64'h0);
        wreg(6'h38, '1);
        rreg(6'h38, 64'h0);
        ptb = {$urandom, $urandom};
        htb = {$urandom, $urandom};
        wreg(`ADDR_PTB, ptb);
        wreg(`ADDR_HTB, htb);
        rreg(`ADDR_PTB, ptb);
        rreg(`ADDR_HTB, htb);
        wreg(`ADDR_TL, 64'h7);
        rreg(`ADDR_TL, 64'h0);
        $display("registers done");
        for (int t = 0; t < 7; t++) begin
            tt = 9'h100 | 9'($urandom_range(127));
            v = {$urandom, $urandom};
            nz = {1'b0, 18'(v[63:32])};
            cpu.trap_little_endian <= v[1];
            wreg(`ADDR_TL, 64'(t));
            give('{mk(tt, 8'h05, v[0]), nz, nz, nz});
            exp_tr.push_back(et(v[0] || t >= 2, 3'(t), tt, v[1]));
            step();
            rreg(`ADDR_TL, (t == 6) ? 64'h6 : 64'(t + 1));
            rreg(`ADDR_TT, 64'(tt));
            rreg(`ADDR_VEC, et(v[0] || t >= 2, 3'(t), tt, v[1]).vector);
        end
        $display("nesting done");
        wreg(`ADDR_TL, 64'h0);
        give('{nz, mk(9'h103, 8'h01, 1'b0), mk(9'h102, 8'h01, 1'b0), mk(9'h101, 8'h03, 1'b0)});
        exp_tr.push_back(et(1'b0, 3'h0, 9'h102, cpu.trap_little_endian));
        exp_tr.push_back(et(1'b0, 3'h1, 9'h103, cpu.trap_little_endian));
        exp_tr.push_back(et(1'b1, 3'h2, 9'h101, cpu.trap_little_endian));
        repeat (3) step();
        $display("priority done");
        wreg(`ADDR_PIL, 64'h5);
        for (int k = 0; k < 5; k++) begin
            v[23:0] = ITAB[k];
            wreg(`ADDR_TL, 64'h0);
            @(posedge clk) {cpu.hyper_priv, cpu.interrupt_enable, irq} <= v[17:0];
            if (v[23:20] != 4'h0)
                exp_tr.push_back(et(1'b0, 3'h0, `IRQ_TT_BASE + 9'(v[23:20]),
                                    cpu.trap_little_endian));
            step();
            @(posedge clk) irq <= 16'h0;
        end
        $display("interrupts done");
        wreg(`ADDR_TL, 64'h0);
        @(posedge clk) {cpu.fp_enable, cpu.float_unit_enable} <= 2'b11;
        wreg(`ADDR_FSR, 64'h0);
        fpop(5'h01, 8'hA5, 1'b1);
        rreg(`ADDR_FSR, 64'hA50100);
        wreg(`ADDR_FSR, 64'h1);
        fpop(5'h01, 8'h3C, 1'b0);
        exp_tr.push_back(et(1'b0, 3'h0, `FP_IEEE_TT, cpu.trap_little_endian));
        step();
        rreg(`ADDR_FSR, 64'h1);
        fpop(5'h02, 8'h3C, 1'b1);
        rreg(`ADDR_FSR, 64'h3C0201);
        @(posedge clk) cpu.fp_enable <= 1'b0;
        fpop(5'h01, 8'h77, 1'b0);
        step();
        rreg(`ADDR_FSR, 64'h3C0201);
        $display("float done");
        wreg(`ADDR_TL, 64'h3);
        @(posedge clk) ret <= 1'b1;
        @(posedge clk) ret <= 1'b0;
        rreg(`ADDR_TL, 64'h2);
        @(posedge clk) rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rreg(`ADDR_TL, 64'h0);
        rreg(`ADDR_PTB, 64'h0);
        $display("return and reset done");
        repeat (5) @(posedge clk);
        if (exp_tr.size() + exp_rd.size() + exp_cm.size() != 0) failures++;
        end_sim();
    end
endmodule
`default_nettype wire
